// ### common/scsc_regs.svh
`ifndef SCSC_REGS_SVH
`define SCSC_REGS_SVH

// register byte addresses
`define SCSC_PMC_ADDR 12'h000
`define SCSC_STAT_ADDR 12'h004
`define SCSC_EXF_ADDR 12'h008
`define SCSC_ADDR_W 12

// power_management_control fields
`define SCSC_PMC_DIV_HI 7
`define SCSC_PMC_DIV_LO 6
`define SCSC_PMC_ARE_BIT 5
`define SCSC_PMC_XOFF_BIT 3

// clock_and_service_status fields
`define SCSC_ST_PF_BIT 7
`define SCSC_ST_HIGH_BIT 6
`define SCSC_ST_LOW_BIT 5
`define SCSC_ST_XRDY_BIT 4
`define SCSC_ST_TXA_BIT 1
`define SCSC_ST_RXA_BIT 0

// extended_flags_clock_source fields
`define SCSC_EXF_SRC_BIT 3
`define SCSC_EXF_RING_BIT 2

// divider encodings
`define SCSC_DIV_4 2'h1
`define SCSC_DIV_64 2'h2
`define SCSC_DIV_1024 2'h3
`define SCSC_DIV_RSVD 2'h0

// clocks per instruction cycle, minus one
`define SCSC_LIM_4 10'h003
`define SCSC_LIM_64 10'h03F
`define SCSC_LIM_1024 10'h3FF

// reset values
`define SCSC_DIV_RST 2'h1
`define SCSC_ARE_RST 1'b0
`define SCSC_XOFF_RST 1'b0
`define SCSC_SRC_RST 1'b1
`define SCSC_XRDY_RST 1'b1

// crystal warm-up, in crystal clocks
`define SCSC_WARMUP_CLKS 65536
`define SCSC_WARM_W 17

// interrupt priority levels (0 = none)
`define SCSC_LVL_NONE 2'h0
`define SCSC_LVL_LOW 2'h1
`define SCSC_LVL_HIGH 2'h2
`define SCSC_LVL_PF 2'h3

// axi responses
`define SCSC_RESP_OKAY 2'h0
`define SCSC_RESP_SLVERR 2'h2

`endif

// ### common/scsc_pkg.sv
package scsc_pkg;

	// status from interrupt controller and uart
	typedef struct packed {
		logic svc_pf;
		logic svc_high;
		logic svc_low;
		logic port0_tx_active;
		logic port0_rx_active;
	} scsc_svc_t;

	// switchback event sources
	typedef struct packed {
		logic ext_irq;
		logic [1:0] ext_irq_lvl;
		logic rx_enable;
		logic rx_start_bit;
	} scsc_wake_t;

	// clock controls to the clock generator
	typedef struct packed {
		logic [1:0] div_sel;
		logic xtal_amp_enable;
		logic xtal_clk_en;
		logic ring_clk_en;
	} scsc_clk_t;

	typedef enum logic [1:0] {
		SRC_XTAL,
		SRC_GAP_TO_RING,
		SRC_RING,
		SRC_GAP_TO_XTAL
	} scsc_src_state_t;

endpackage

// ### src/scsc_ctrl.sv
`timescale 1ns/1ns
`include "scsc_regs.svh"
// What this block does
// - status bits 7,6,5 show power-fail, high, low levels in service
// - status bit 0 is set while port 0 receives a word
// - status bit 1 is set while port 0 shifts out a transmission
// - divider writes are ignored while any port 0 activity flag is set
// - source select bit 3: one picks crystal, zero picks ring oscillator
// - read-only ring flag bit 2 is one while cpu runs from ring
// - amplifier disable bit 3 stops crystal; settable only while source select is zero
// - source change takes effect at the next instruction cycle boundary after the write
// - clearing amplifier disable restarts crystal; ready flag sets 65536 clocks later
// - source select to one is blocked until ready is one and disable zero
// - automatic return restores only the divider; source select is untouched
// - divider bits 7:6: 01 four clocks, 10 slow one, 11 slow two; reset 01
// - divider write of 10 or 11 accepted only while divider is 01
// - auto return enable bit 5 gates hardware return; resets zero; writes unrestricted
// - after reset ready reads one, other flags zero; flags ignore writes
// - after reset the crystal is the selected cpu clock source
// - interrupts at or below the level in service cause no automatic return
// - with auto return, valid external interrupt or start bit sets divider to 01
module scsc_ctrl #(
	parameter int unsigned WARMUP_CLKS = `SCSC_WARMUP_CLKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire scsc_pkg::scsc_svc_t svc,
	input wire scsc_pkg::scsc_wake_t wake,
	output scsc_pkg::scsc_clk_t clk_ctl
);

	// ---------------- axi4-lite slave ----------------
	logic aw_have_q;
	logic [11:0] aw_addr_q;
	logic w_have_q;
	logic [7:0] w_byte_q;
	logic w_lane0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wr_fire;
	logic wr_hit;
	logic pmc_wr;
	logic exf_wr;
	logic rd_take;

	assign s_axi_awready = ce && !aw_have_q;
	assign s_axi_wready = ce && !w_have_q;
	assign s_axi_arready = ce && !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// both halves held until the response is accepted, so one write at a time
	assign wr_fire = ce && aw_have_q && w_have_q && !bvalid_q;
	assign wr_hit = (aw_addr_q == `SCSC_PMC_ADDR) || (aw_addr_q == `SCSC_STAT_ADDR)
		|| (aw_addr_q == `SCSC_EXF_ADDR);
	assign pmc_wr = wr_fire && w_lane0_q && (aw_addr_q == `SCSC_PMC_ADDR);
	assign exf_wr = wr_fire && w_lane0_q && (aw_addr_q == `SCSC_EXF_ADDR);
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
		end else if (ce) begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[11:2], 2'h0};
			end else if (bvalid_q && s_axi_bready) begin
				aw_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_byte_q <= 8'h00;
			w_lane0_q <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				w_byte_q <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end else if (bvalid_q && s_axi_bready) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `SCSC_RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `SCSC_RESP_OKAY : `SCSC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ---------------- divider and auto return ----------------
	logic [1:0] div_sel_q;
	logic [1:0] div_eff_q;
	logic are_q;
	logic [1:0] svc_top;
	logic irq_ok;
	logic swb_fire;
	logic port_busy;
	logic div_ok;
	logic [1:0] div_new;

	assign port_busy = svc.port0_tx_active || svc.port0_rx_active;
	assign div_new = w_byte_q[`SCSC_PMC_DIV_HI:`SCSC_PMC_DIV_LO];
	// slow codes only from 01; 01 always; reserved 00 dropped
	assign div_ok = (div_new == `SCSC_DIV_4)
		|| ((div_new != `SCSC_DIV_RSVD) && (div_sel_q == `SCSC_DIV_4));

	always_comb begin
		if (svc.svc_pf) begin
			svc_top = `SCSC_LVL_PF;
		end else if (svc.svc_high) begin
			svc_top = `SCSC_LVL_HIGH;
		end else if (svc.svc_low) begin
			svc_top = `SCSC_LVL_LOW;
		end else begin
			svc_top = `SCSC_LVL_NONE;
		end
	end

	// an interrupt only counts if it could really preempt the level in service
	assign irq_ok = wake.ext_irq && (wake.ext_irq_lvl > svc_top);
	assign swb_fire = are_q && (div_sel_q != `SCSC_DIV_4)
		&& (irq_ok || (wake.rx_enable && wake.rx_start_bit));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_sel_q <= `SCSC_DIV_RST;
		end else if (ce) begin
			if (swb_fire) begin
				div_sel_q <= `SCSC_DIV_4;
			end else if (pmc_wr && !port_busy && div_ok) begin
				div_sel_q <= div_new;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			are_q <= `SCSC_ARE_RST;
		end else if (ce && pmc_wr) begin
			are_q <= w_byte_q[`SCSC_PMC_ARE_BIT];
		end
	end

	// ---------------- instruction cycle timing ----------------
	logic [9:0] cyc_cnt_q;
	logic [9:0] cyc_lim;
	logic instr_tick;

	always_comb begin
		case (div_eff_q)
			`SCSC_DIV_64: cyc_lim = `SCSC_LIM_64;
			`SCSC_DIV_1024: cyc_lim = `SCSC_LIM_1024;
			default: cyc_lim = `SCSC_LIM_4;
		endcase
	end

	assign instr_tick = ce && (cyc_cnt_q >= cyc_lim);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_cnt_q <= 10'h000;
		end else if (ce) begin
			cyc_cnt_q <= instr_tick ? 10'h000 : cyc_cnt_q + 10'h001;
		end
	end

	// new divider applies at the next instruction cycle boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_eff_q <= `SCSC_DIV_RST;
		end else if (instr_tick) begin
			div_eff_q <= div_sel_q;
		end
	end

	// ---------------- crystal amplifier and warm-up ----------------
	logic xoff_q;
	logic xrdy_q;
	logic [`SCSC_WARM_W-1:0] warm_cnt_q;
	logic src_sel_q;

	// aclk is taken as the crystal's own clock while it runs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xoff_q <= `SCSC_XOFF_RST;
		end else if (ce && pmc_wr) begin
			if (w_byte_q[`SCSC_PMC_XOFF_BIT] && !src_sel_q) begin
				xoff_q <= 1'b1;
			end else if (!w_byte_q[`SCSC_PMC_XOFF_BIT]) begin
				xoff_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xrdy_q <= `SCSC_XRDY_RST;
			warm_cnt_q <= '0;
		end else if (ce) begin
			if (xoff_q) begin
				xrdy_q <= 1'b0;
				warm_cnt_q <= '0;
			end else if (!xrdy_q) begin
				if (warm_cnt_q == `SCSC_WARM_W'(WARMUP_CLKS - 1)) begin
					xrdy_q <= 1'b1;
				end
				warm_cnt_q <= warm_cnt_q + `SCSC_WARM_W'(1);
			end
		end
	end

	// ---------------- clock source select and switch ----------------
	scsc_pkg::scsc_src_state_t src_st_q;
	logic xtal_en_q;
	logic ring_en_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_sel_q <= `SCSC_SRC_RST;
		end else if (ce && exf_wr) begin
			if (!w_byte_q[`SCSC_EXF_SRC_BIT]) begin
				src_sel_q <= 1'b0;
			end else if (xrdy_q && !xoff_q) begin
				src_sel_q <= 1'b1;
			end
		end
	end

	// break before make: both gates closed until the next instruction cycle boundary so
	// neither clock is cut mid-pulse, at the cost of a short pause
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_st_q <= scsc_pkg::SRC_XTAL;
			xtal_en_q <= 1'b1;
			ring_en_q <= 1'b0;
		end else if (ce) begin
			case (src_st_q)
				scsc_pkg::SRC_XTAL: begin
					if (!src_sel_q) begin
						src_st_q <= scsc_pkg::SRC_GAP_TO_RING;
						xtal_en_q <= 1'b0;
					end
				end
				scsc_pkg::SRC_GAP_TO_RING: begin
					if (instr_tick) begin
						src_st_q <= scsc_pkg::SRC_RING;
						ring_en_q <= 1'b1;
					end
				end
				scsc_pkg::SRC_RING: begin
					if (src_sel_q) begin
						src_st_q <= scsc_pkg::SRC_GAP_TO_XTAL;
						ring_en_q <= 1'b0;
					end
				end
				scsc_pkg::SRC_GAP_TO_XTAL: begin
					if (instr_tick) begin
						src_st_q <= scsc_pkg::SRC_XTAL;
						xtal_en_q <= 1'b1;
					end
				end
				default: begin
					src_st_q <= scsc_pkg::SRC_XTAL;
					xtal_en_q <= 1'b1;
					ring_en_q <= 1'b0;
				end
			endcase
		end
	end

	assign clk_ctl.div_sel = div_eff_q;
	assign clk_ctl.xtal_amp_enable = !xoff_q;
	assign clk_ctl.xtal_clk_en = xtal_en_q;
	assign clk_ctl.ring_clk_en = ring_en_q;

	// ---------------- register read ----------------
	logic [7:0] pmc_rd;
	logic [7:0] stat_rd;
	logic [7:0] exf_rd;

	assign pmc_rd = {div_sel_q, are_q, 1'b0, xoff_q, 3'h0};
	// status is wired live from its sources; writes never reach it
	assign stat_rd = {svc.svc_pf, svc.svc_high, svc.svc_low, xrdy_q, 2'h0,
		svc.port0_tx_active, svc.port0_rx_active};
	assign exf_rd = {4'h0, src_sel_q, ring_en_q, 2'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= `SCSC_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (rd_take) begin
				rvalid_q <= 1'b1;
				rresp_q <= `SCSC_RESP_OKAY;
				case ({s_axi_araddr[11:2], 2'h0})
					`SCSC_PMC_ADDR: rdata_q <= {24'h00_0000, pmc_rd};
					`SCSC_STAT_ADDR: rdata_q <= {24'h00_0000, stat_rd};
					`SCSC_EXF_ADDR: rdata_q <= {24'h00_0000, exf_rd};
					default: begin
						rdata_q <= 32'h0000_0000;
						rresp_q <= `SCSC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
	// ---------------- assertions ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_div_busy_lock: assert property (ce && pmc_wr && port_busy && !swb_fire
		|=> div_sel_q == $past(div_sel_q))
		else $error("divider changed while port 0 busy");
	a_div_slow_entry: assert property (ce && $changed(div_sel_q) && div_sel_q != `SCSC_DIV_4
		|-> $past(div_sel_q) == `SCSC_DIV_4)
		else $error("slow divider entered from a slow code");
	// a software source write in the same cycle may legally move the select
	a_swb_restore: assert property (ce && swb_fire && !exf_wr
		|=> div_sel_q == `SCSC_DIV_4 && src_sel_q == $past(src_sel_q))
		else $error("switchback wrong divider or moved source");
	a_swb_lockout: assert property (ce && are_q && div_sel_q != `SCSC_DIV_4 && !pmc_wr
		&& !(wake.rx_enable && wake.rx_start_bit) && wake.ext_irq && wake.ext_irq_lvl <= svc_top
		|=> div_sel_q == $past(div_sel_q))
		else $error("locked-out interrupt caused switchback");
	a_swb_off: assert property (!are_q && !pmc_wr |=> $stable(div_sel_q))
		else $error("divider moved without enable or write");
	a_xoff_guard: assert property ($rose(xoff_q) |-> $past(!src_sel_q))
		else $error("amplifier stopped while crystal selected");
	a_src_guard: assert property ($rose(src_sel_q) |-> $past(xrdy_q && !xoff_q))
		else $error("crystal selected before ready");
	a_ring_flag: assert property (exf_rd[`SCSC_EXF_RING_BIT] == ring_en_q
		&& !(ring_en_q && xtal_en_q))
		else $error("ring flag or gates inconsistent");
	sequence s_gap_open;
		ce && src_st_q == scsc_pkg::SRC_XTAL && !src_sel_q;
	endsequence
	sequence s_gap_held;
		!xtal_en_q && !ring_en_q;
	endsequence
	a_switch_gap: assert property (s_gap_open |=> s_gap_held)
		else $error("no dead gap on source switch");
	logic [`SCSC_WARM_W:0] warm_obs_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || xoff_q || xrdy_q) begin
			warm_obs_q <= '0;
		end else if (ce) begin
			warm_obs_q <= warm_obs_q + (`SCSC_WARM_W+1)'(1);
		end
	end
	a_warm_exact: assert property ($rose(xrdy_q)
		|-> $past(warm_obs_q) == (`SCSC_WARM_W+1)'(WARMUP_CLKS - 1))
		else $error("crystal ready not after warm-up count");
	a_ring_one_cycle: assert property (src_st_q == scsc_pkg::SRC_GAP_TO_RING && instr_tick
		|=> ring_en_q ##1 ring_en_q || src_sel_q)
		else $error("ring not enabled at instruction boundary");
endmodule // scsc_ctrl

// ### tb/tb.sv
`timescale 1ns/1ns
`include "scsc_regs.svh"
module tb;
	localparam int WARM = 16;
	localparam logic [11:0] PMC = `SCSC_PMC_ADDR;
	localparam logic [11:0] STA = `SCSC_STAT_ADDR;
	localparam logic [11:0] EXF = `SCSC_EXF_ADDR;
	localparam logic [1:0] OK = `SCSC_RESP_OKAY;
	localparam logic [1:0] ERR = `SCSC_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn, ce;
	logic [11:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	scsc_pkg::scsc_svc_t svc;
	scsc_pkg::scsc_wake_t wake;
	scsc_pkg::scsc_clk_t clk_ctl;
	logic [33:0] exq[$];
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;

	always #20 aclk = ~aclk;

	scsc_ctrl #(.WARMUP_CLKS(WARM)) dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .svc(svc), .wake(wake),
		.clk_ctl(clk_ctl));

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic pop_cmp(input logic [33:0] seen);
		if (exq.size() == 0) begin
			errors++;
			$display("Error at %0t: unexpected answer %h", $time, seen);
		end else begin
			check(seen, exq.pop_front());
		end
	endtask

	// answers are compared in the order the driver noted them
	always @(posedge aclk) begin
		cyc++;
		if (aresetn && bvalid && bready) begin
			pop_cmp({bresp, 32'h0});
		end
		if (aresetn && rvalid && rready) begin
			pop_cmp({rresp, rdata});
		end
		if (aresetn) begin
			check({33'h0, clk_ctl.xtal_clk_en & clk_ctl.ring_clk_en}, 34'h0);
		end
		if (cyc >= 4000) begin
			errors++;
			finish_test();
		end
	end

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] resp);
		logic aw_ok;
		logic w_ok;
		logic [31:0] r;
		r = $urandom();
		aw_ok = 1'b0;
		w_ok = 1'b0;
		exq.push_back({resp, 32'h0});
		awaddr <= a;
		wdata <= {r[31:8], d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp);
		exq.push_back({resp, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic chk_clk(input logic [4:0] e);
		check({29'h0, clk_ctl}, {29'h0, e});
	endtask

	task automatic rx_pulse();
		wake.rx_start_bit <= 1'b1;
		@(posedge aclk);
		wake.rx_start_bit <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic irq(input logic [1:0] l);
		wake.ext_irq_lvl <= l;
		wake.ext_irq <= 1'b1;
		@(posedge aclk);
		wake.ext_irq <= 1'b0;
		@(posedge aclk);
	endtask

	initial begin
		logic [31:0] s;
		aresetn = 1'b0;
		ce = 1'b1;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		svc = '0;
		wake = '0;
		s = $urandom(8497);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_clk(5'h0E);
		rd(PMC, 8'h40, OK);
		rd(STA, 8'h10, OK);
		rd(EXF, 8'h08, OK);
		// status bits follow the live inputs
		for (int i = 0; i < 6; i++) begin
			s = $urandom();
			svc <= s[4:0];
			rd(STA, {s[4:2], 1'b1, 2'b00, s[1:0]}, OK);
		end
		svc <= '0;
		wr(STA, 8'hFF, 4'hF, OK);
		rd(STA, 8'h10, OK);
		wr(12'h00C, 8'h55, 4'hF, ERR);
		rd(12'h00C, 8'h00, ERR);
		wake.rx_enable <= 1'b1;
		wr(PMC, 8'h80, 4'hF, OK);
		rd(PMC, 8'h80, OK);
		tick(8);
		chk_clk(5'h16);
		wr(PMC, 8'hC0, 4'hF, OK);
		rd(PMC, 8'h80, OK);
		wr(PMC, 8'h20, 4'hF, OK);
		rd(PMC, 8'hA0, OK);
		// a high level in service locks out low and high sources
		svc.svc_high <= 1'b1;
		irq(`SCSC_LVL_LOW);
		irq(`SCSC_LVL_HIGH);
		rd(PMC, 8'hA0, OK);
		irq(`SCSC_LVL_PF);
		rd(PMC, 8'h60, OK);
		svc.svc_high <= 1'b0;
		wr(PMC, 8'h80, 4'hF, OK);
		rx_pulse();
		rd(PMC, 8'h80, OK);
		wake.rx_enable <= 1'b0;
		wr(PMC, 8'hA0, 4'hF, OK);
		rx_pulse();
		rd(PMC, 8'hA0, OK);
		wake.rx_enable <= 1'b1;
		rx_pulse();
		rd(PMC, 8'h60, OK);
		tick(70);
		chk_clk(5'h0E);
		svc.port0_tx_active <= 1'b1;
		// auto return bit stays set: only the divider field is guarded
		wr(PMC, 8'hA0, 4'hF, OK);
		rd(PMC, 8'h60, OK);
		svc <= 5'h01;
		wr(PMC, 8'hE0, 4'hF, OK);
		rd(PMC, 8'h60, OK);
		svc <= '0;
		wr(PMC, 8'h80, 4'h0, OK);
		rd(PMC, 8'h60, OK);
		// crystal to ring and back
		wr(PMC, 8'h68, 4'hF, OK);
		rd(PMC, 8'h60, OK);
		wr(EXF, 8'h00, 4'hF, OK);
		tick(8);
		chk_clk(5'h0D);
		rd(EXF, 8'h04, OK);
		wr(PMC, 8'h68, 4'hF, OK);
		rd(PMC, 8'h68, OK);
		chk_clk(5'h09);
		rd(STA, 8'h00, OK);
		wr(EXF, 8'h08, 4'hF, OK);
		rd(EXF, 8'h04, OK);
		wr(PMC, 8'h60, 4'hF, OK);
		rd(STA, 8'h00, OK);
		// frozen cycles must not count towards the warm-up
		ce <= 1'b0;
		tick(WARM);
		ce <= 1'b1;
		rd(STA, 8'h00, OK);
		tick(WARM);
		rd(STA, 8'h10, OK);
		wr(PMC, 8'hE0, 4'hF, OK);
		rd(PMC, 8'hE0, OK);
		tick(8);
		chk_clk(5'h1D);
		rx_pulse();
		rd(PMC, 8'h60, OK);
		rd(EXF, 8'h04, OK);
		tick(1030);
		chk_clk(5'h0D);
		wr(EXF, 8'h08, 4'hF, OK);
		tick(8);
		rd(EXF, 8'h08, OK);
		chk_clk(5'h0E);
		tick(4);
		finish_test();
	end
endmodule // tb
